/* File: hdl/abc_consts.vh */
// Purpose: Shared constants of the axis backlash compensation block.
// Assumes: Word-indexed register port, 20 MHz core clock.
// Notes: Included by the design modules, the monitor and the test bench.
`ifndef ABC_CONSTS_VH
`define ABC_CONSTS_VH

`define ABC_ADDR_W 5
`define ABC_DATA_W 32
`define ABC_INCR_W 16
`define ABC_OUT_W 24
`define ABC_AMT_W 16
`define ABC_ACC_W 24
`define ABC_NUM_W 48
`define ABC_ENTRIES 4

`define ABC_REG_CTRL 5'h00
`define ABC_REG_RAPID 5'h01
`define ABC_REG_CUT 5'h02
`define ABC_REG_RATE0 5'h03
`define ABC_REG_CORR0 5'h07
`define ABC_REG_STATUS 5'h0b
`define ABC_REG_LAST 5'h0c

`define ABC_CTRL_EN_BIT 0
`define ABC_CTRL_UNIT_BIT 1
`define ABC_CTRL_RST 2'h0
`define ABC_AMT_RST 16'h0000
`define ABC_RATE_RST 24'h000000
`define ABC_UNIT_SCALE 8'h0a

`define ABC_DIV_STEPS 6'h30

`endif

/* File: hdl/abc_div.v */
// Purpose: Sequential unsigned divider for the interpolation step.
// Assumes: Divisor is never zero while a division runs.
// Notes: One quotient bit per enabled clock, done is a one-cycle pulse.
`timescale 1ns/100ps
`include "abc_consts.vh"

module abc_div (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire start,
    input wire [`ABC_NUM_W-1:0] dividend,
    input wire [`ABC_ACC_W-1:0] divisor,
    output wire busy,
    output reg done,
    output wire [`ABC_NUM_W-1:0] quotient
);
    reg busy_reg;
    reg [5:0] cnt_reg;
    reg [`ABC_NUM_W-1:0] quo_reg;
    reg [`ABC_ACC_W:0] rem_reg;
    wire [`ABC_ACC_W:0] trial;
    wire [`ABC_ACC_W:0] divisor_x;

    assign trial = {rem_reg[`ABC_ACC_W-1:0], quo_reg[`ABC_NUM_W-1]};
    assign divisor_x = {1'b0, divisor};
    assign busy = busy_reg;
    assign quotient = quo_reg;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            done <= 1'b0;
            cnt_reg <= 6'h00;
            quo_reg <= {`ABC_NUM_W{1'b0}};
            rem_reg <= {(`ABC_ACC_W+1){1'b0}};
        end else if (clk_en) begin
            done <= 1'b0;
            if (start && !busy_reg) begin
                busy_reg <= 1'b1;
                cnt_reg <= 6'h00;
                quo_reg <= dividend;
                rem_reg <= {(`ABC_ACC_W+1){1'b0}};
            end else if (busy_reg) begin
                if (trial >= divisor_x) begin
                    rem_reg <= trial - divisor_x;
                    quo_reg <= {quo_reg[`ABC_NUM_W-2:0], 1'b1};
                end else begin
                    rem_reg <= trial;
                    quo_reg <= {quo_reg[`ABC_NUM_W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg + 6'h01;
                if (cnt_reg == `ABC_DIV_STEPS - 6'h01) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: hdl/abc_backlash.v */
// Purpose: Backlash compensation for one axis of a numerical controller.
// Assumes: One instance per axis; motion commands come from same-clock logic.
// Notes: Registers are word indexed on a plain strobe port.
// Behaviour
// - On every direction reversal add a backlash correction to the axis travel.
// - Rapid traverse reversals use the rapid traverse backlash amount.
// - Cutting feed reversals use the cutting feed backlash amount.
// - Acceleration mode holds four rate and amount pairs, uses acceleration at reversal.
// - Between two configured rates the amount is linearly interpolated.
// - Acceleration mode needs option present, axis enable on, first rate nonzero.
// - Acceleration mode enable is kept separately for each axis.
// - Configured rates are accelerations at reversal in micrometres per second squared.
// - Acceleration amounts are scaled by the selected compensation unit.
// - Amount k pairs with rate k for k from one to four.
// - A positive amount acts in the travel direction after reversal.
// - A negative amount acts in the travel direction before reversal.
// - With first rate zero no acceleration correction is made, amount is zero; the code applies the fixed rapid or cutting amount instead.
// - From the first rate not above its predecessor, that and later pairs are ignored.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
`include "abc_consts.vh"

module abc_backlash (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [`ABC_ADDR_W-1:0] reg_addr,
    input wire [`ABC_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`ABC_DATA_W-1:0] reg_rdata,
    input wire accel_option,
    input wire cmd_valid,
    output wire cmd_ready,
    input wire signed [`ABC_INCR_W-1:0] cmd_incr,
    input wire cmd_rapid,
    input wire [`ABC_ACC_W-1:0] accel_meas,
    output reg out_valid,
    output reg signed [`ABC_OUT_W-1:0] out_incr
);
    localparam ST_IDLE = 2'h0;
    localparam ST_DIV = 2'h1;
    localparam ST_OUT = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] ctrl_reg;
    reg signed [`ABC_AMT_W-1:0] rapid_backlash_amount_reg;
    reg signed [`ABC_AMT_W-1:0] cutting_backlash_amount_reg;
    reg [`ABC_ACC_W-1:0] rate_reg [0:`ABC_ENTRIES-1];
    reg signed [`ABC_AMT_W-1:0] corr_reg [0:`ABC_ENTRIES-1];
    reg moved_reg;
    reg dir_reg;
    reg signed [`ABC_INCR_W-1:0] hold_incr_reg;
    reg hold_dir_reg;
    reg signed [`ABC_AMT_W:0] hold_base_reg;
    reg hold_neg_reg;
    reg signed [`ABC_OUT_W-1:0] last_corr_reg;
    wire [`ABC_ENTRIES-1:0] valid;
    wire accel_backlash_enable;
    wire accel_mode;
    wire new_dir;
    wire reversal;
    wire div_busy;
    wire div_done;
    wire [`ABC_NUM_W-1:0] div_quo;
    reg [1:0] seg;
    reg [1:0] seg_hi;
    reg seg_last;
    reg below;
    reg need_div;
    reg signed [`ABC_AMT_W:0] amt;
    reg signed [`ABC_AMT_W:0] dc;
    reg [`ABC_AMT_W:0] dc_mag;
    reg [`ABC_ACC_W-1:0] da_num;
    reg [`ABC_ACC_W-1:0] da_den;
    reg [`ABC_NUM_W-1:0] product;
    reg signed [`ABC_OUT_W-1:0] corr_out;
    reg signed [`ABC_OUT_W-1:0] scaled;
    reg signed [`ABC_OUT_W-1:0] interp;
    reg signed [`ABC_OUT_W-1:0] quo_s;
    integer k;

    assign accel_backlash_enable = ctrl_reg[`ABC_CTRL_EN_BIT];
    // Each instance owns its enable, so axes never share the mode.
    assign accel_mode = accel_option && accel_backlash_enable && valid[0];
    assign cmd_ready = (state_reg == ST_IDLE);
    assign new_dir = cmd_incr[`ABC_INCR_W-1];
    assign reversal = (cmd_incr != {`ABC_INCR_W{1'b0}}) && moved_reg && (new_dir != dir_reg);

    // Valid prefix of the table: a pair counts only while rates keep rising.
    assign valid[0] = (rate_reg[0] != `ABC_RATE_RST);
    genvar g;
    generate
        for (g = 1; g < `ABC_ENTRIES; g = g + 1) begin : g_valid
            assign valid[g] = valid[g-1] && (rate_reg[g] > rate_reg[g-1]);
        end
        for (g = 0; g < `ABC_ENTRIES; g = g + 1) begin : g_table
            always @(posedge core_clk) begin
                if (!rst_n) begin
                    rate_reg[g] <= `ABC_RATE_RST;
                    corr_reg[g] <= `ABC_AMT_RST;
                end else if (clk_en && reg_wr) begin
                    if (reg_addr == `ABC_REG_RATE0 + g) begin
                        rate_reg[g] <= reg_wdata[`ABC_ACC_W-1:0];
                    end
                    if (reg_addr == `ABC_REG_CORR0 + g) begin
                        corr_reg[g] <= reg_wdata[`ABC_AMT_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // Segment choice and interpolation operands for the present acceleration.
    always @* begin
        seg = 2'h0;
        for (k = 1; k < `ABC_ENTRIES; k = k + 1) begin
            if (valid[k] && accel_meas >= rate_reg[k]) begin
                seg = k[1:0];
            end
        end
        seg_hi = seg + 2'h1;
        seg_last = (seg == 2'h3) || !valid[seg_hi];
        below = accel_meas < rate_reg[0];
        need_div = !below && !seg_last && (accel_meas != rate_reg[seg]);
        dc = {corr_reg[seg_hi][`ABC_AMT_W-1], corr_reg[seg_hi]}
            - {corr_reg[seg][`ABC_AMT_W-1], corr_reg[seg]};
        dc_mag = dc[`ABC_AMT_W] ? (~dc + 17'h00001) : dc;
        da_num = accel_meas - rate_reg[seg];
        da_den = rate_reg[seg_hi] - rate_reg[seg];
        product = {24'h000000, da_num} * {31'h00000000, dc_mag};
        if (accel_mode) begin
            amt = below ? {corr_reg[0][`ABC_AMT_W-1], corr_reg[0]}
                : {corr_reg[seg][`ABC_AMT_W-1], corr_reg[seg]};
        end else if (cmd_rapid) begin
            amt = {rapid_backlash_amount_reg[`ABC_AMT_W-1], rapid_backlash_amount_reg};
        end else begin
            amt = {cutting_backlash_amount_reg[`ABC_AMT_W-1],
                cutting_backlash_amount_reg};
        end
    end

    // Interpolated amount once the divider has finished.
    always @* begin
        quo_s = div_quo[`ABC_OUT_W-1:0];
        interp = {{(`ABC_OUT_W-`ABC_AMT_W-1){hold_base_reg[`ABC_AMT_W]}}, hold_base_reg}
            + (hold_neg_reg ? -quo_s : quo_s);
    end

    // Unit scaling, then direction: the sign of the amount picks old or new travel.
    always @* begin
        if (state_reg == ST_DIV) begin
            scaled = interp;
        end else begin
            scaled = {{(`ABC_OUT_W-`ABC_AMT_W-1){amt[`ABC_AMT_W]}}, amt};
        end
        if (ctrl_reg[`ABC_CTRL_UNIT_BIT] && (accel_mode || state_reg == ST_DIV)) begin
            scaled = scaled * $signed({16'h0000, `ABC_UNIT_SCALE});
        end
        if (state_reg == ST_DIV ? hold_dir_reg : new_dir) begin
            corr_out = -scaled;
        end else begin
            corr_out = scaled;
        end
    end

    abc_div u_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .start(state_reg == ST_IDLE && cmd_valid && reversal && accel_mode && need_div),
        .dividend(product),
        .divisor(da_den),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_quo)
    );

    always @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            moved_reg <= 1'b0;
            dir_reg <= 1'b0;
            hold_incr_reg <= {`ABC_INCR_W{1'b0}};
            hold_dir_reg <= 1'b0;
            hold_base_reg <= {(`ABC_AMT_W+1){1'b0}};
            hold_neg_reg <= 1'b0;
            last_corr_reg <= {`ABC_OUT_W{1'b0}};
            out_valid <= 1'b0;
            out_incr <= {`ABC_OUT_W{1'b0}};
        end else if (clk_en) begin
            out_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        if (cmd_incr != {`ABC_INCR_W{1'b0}}) begin
                            moved_reg <= 1'b1;
                            dir_reg <= new_dir;
                        end
                        if (reversal && accel_mode && need_div) begin
                            hold_incr_reg <= cmd_incr;
                            hold_dir_reg <= new_dir;
                            hold_base_reg <= amt;
                            hold_neg_reg <= dc[`ABC_AMT_W];
                            state_reg <= ST_DIV;
                        end else if (reversal) begin
                            out_valid <= 1'b1;
                            out_incr <= {{(`ABC_OUT_W-`ABC_INCR_W){cmd_incr[`ABC_INCR_W-1]}},
                                cmd_incr} + corr_out;
                            last_corr_reg <= corr_out;
                        end else begin
                            out_valid <= 1'b1;
                            out_incr <= {{(`ABC_OUT_W-`ABC_INCR_W){cmd_incr[`ABC_INCR_W-1]}},
                                cmd_incr};
                        end
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        out_valid <= 1'b1;
                        out_incr <= {{(`ABC_OUT_W-`ABC_INCR_W){hold_incr_reg[`ABC_INCR_W-1]}},
                            hold_incr_reg} + corr_out;
                        last_corr_reg <= corr_out;
                        state_reg <= ST_OUT;
                    end
                end
                ST_OUT: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Register writes for control and fixed amounts.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= `ABC_CTRL_RST;
            rapid_backlash_amount_reg <= `ABC_AMT_RST;
            cutting_backlash_amount_reg <= `ABC_AMT_RST;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `ABC_REG_CTRL: ctrl_reg <= reg_wdata[1:0];
                `ABC_REG_RAPID: rapid_backlash_amount_reg <= reg_wdata[`ABC_AMT_W-1:0];
                `ABC_REG_CUT: cutting_backlash_amount_reg <= reg_wdata[`ABC_AMT_W-1:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Read data stand in the cycle after the read strobe; unmapped reads give zero.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                if (reg_addr == `ABC_REG_CTRL) begin
                    reg_rdata <= {30'h00000000, ctrl_reg};
                end else if (reg_addr == `ABC_REG_RAPID) begin
                    reg_rdata <= {{16{rapid_backlash_amount_reg[15]}},
                        rapid_backlash_amount_reg};
                end else if (reg_addr == `ABC_REG_CUT) begin
                    reg_rdata <= {{16{cutting_backlash_amount_reg[15]}},
                        cutting_backlash_amount_reg};
                end else if (reg_addr >= `ABC_REG_RATE0 && reg_addr < `ABC_REG_CORR0) begin
                    reg_rdata <= {8'h00, rate_reg[reg_addr[1:0] - 2'h3]};
                end else if (reg_addr >= `ABC_REG_CORR0 && reg_addr < `ABC_REG_STATUS) begin
                    reg_rdata <= {{16{corr_reg[reg_addr[1:0] - 2'h3][15]}},
                        corr_reg[reg_addr[1:0] - 2'h3]};
                end else if (reg_addr == `ABC_REG_STATUS) begin
                    reg_rdata <= {24'h000000, div_busy, dir_reg, moved_reg, valid, accel_mode};
                end else if (reg_addr == `ABC_REG_LAST) begin
                    reg_rdata <= {{8{last_corr_reg[`ABC_OUT_W-1]}}, last_corr_reg};
                end
            end
        end
    end
endmodule

/* File: tb/abc_backlash_monitor.sv */
// Purpose: Port checker for the backlash compensation block.
// Assumes: Shadows only the enable bit, fixed amounts, first rate and the last nonzero direction.
// Notes: Bound into every abc_backlash instance.
`timescale 1ns/100ps
`include "abc_consts.vh"
module abc_backlash_monitor (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [4:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire accel_option,
    input wire cmd_valid,
    input wire cmd_ready,
    input wire signed [15:0] cmd_incr,
    input wire cmd_rapid,
    input wire [23:0] accel_meas,
    input wire out_valid,
    input wire signed [23:0] out_incr
);
    logic en_reg, r1nz_reg, moved_reg, dir_reg;
    logic signed [15:0] rapid_reg, cut_reg;
    wire taken = cmd_valid && cmd_ready && clk_en;
    wire mode = accel_option && en_reg && r1nz_reg;
    wire rev = taken && moved_reg && cmd_incr != 0 && cmd_incr[15] != dir_reg;
    wire signed [23:0] amt = cmd_rapid ? rapid_reg : cut_reg;
    wire signed [23:0] fix_exp = cmd_incr[15] ? 24'(cmd_incr) - amt : 24'(cmd_incr) + amt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the configuration and of the last nonzero direction.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {en_reg, r1nz_reg, moved_reg, dir_reg} <= 4'h0;
            rapid_reg <= 16'h0000;
            cut_reg <= 16'h0000;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `ABC_REG_CTRL) en_reg <= reg_wdata[0];
            if (reg_wr && reg_addr == `ABC_REG_RAPID) rapid_reg <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `ABC_REG_CUT) cut_reg <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `ABC_REG_RATE0) r1nz_reg <= reg_wdata[23:0] != 24'h0;
            if (taken && cmd_incr != 0) moved_reg <= 1'b1;
            if (taken && cmd_incr != 0) dir_reg <= cmd_incr[15];
        end
    end
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
    property p_rd_unmapped; reg_rd && reg_addr > `ABC_REG_LAST |=> reg_rdata == 32'h0; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_plain; taken && !rev |=> out_valid && out_incr == 24'($past(cmd_incr)); endproperty
    a_plain: assert property (p_plain) else $error("plain increment altered");
    property p_fixed; rev && !mode |=> out_valid && out_incr == $past(fix_exp); endproperty
    a_fixed: assert property (p_fixed) else $error("fixed correction wrong");
    property p_div_lat; $fell(cmd_ready) |-> ##49 out_valid; endproperty
    a_div_lat: assert property (p_div_lat) else $error("interpolated answer late");
    property p_div_quiet; $fell(cmd_ready) |-> !out_valid [*8]; endproperty
    a_div_quiet: assert property (p_div_quiet) else $error("early answer");
    property p_div_back; $fell(cmd_ready) |-> ##[48:51] cmd_ready; endproperty
    a_div_back: assert property (p_div_back) else $error("ready not back");
    property p_no_div; taken && !mode |=> cmd_ready; endproperty
    a_no_div: assert property (p_no_div) else $error("division with mode off");
    property p_cause; out_valid && $past(cmd_ready) |-> $past(cmd_valid); endproperty
    a_cause: assert property (p_cause) else $error("output without command");
    c_div: cover property ($fell(cmd_ready));
    c_fixed: cover property (rev && !mode);
    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind abc_backlash abc_backlash_monitor abc_backlash_monitor_i (.core_clk(core_clk),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .accel_option(accel_option),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_incr(cmd_incr), .cmd_rapid(cmd_rapid),
    .accel_meas(accel_meas), .out_valid(out_valid), .out_incr(out_incr));

/* File: tb/abc_servo_model.sv */
// Purpose: Servo drive that integrates compensated increments.
// Assumes: Increments arrive with out_valid.
// Notes: Position lets the bench compare total travel.
`timescale 1ns/100ps
module abc_servo_model (
    input wire core_clk,
    input wire rst_n,
    input wire out_valid,
    input wire signed [23:0] out_incr,
    output logic signed [31:0] position
);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            position <= 32'h0;
        end else if (out_valid) begin
            position <= position + 32'(out_incr);
        end
    end
endmodule

/* File: tb/test_abc_backlash.sv */
// Purpose: Self-checking bench for the backlash compensation block.
// Assumes: Clock enable held high.
// Notes: Expected corrections are recomputed from the configuration.
`timescale 1ns/100ps
`include "abc_consts.vh"
module test_abc_backlash;
    logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, accel_option = 1;
    logic cmd_valid = 0, cmd_rapid = 0;
    logic [4:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic signed [15:0] cmd_incr = 0;
    logic [23:0] accel_meas = 0;
    wire [31:0] reg_rdata;
    wire cmd_ready, out_valid;
    wire signed [23:0] out_incr;
    wire signed [31:0] position;
    int fails = 0, tests_run = 0, pos_exp = 0, lat, il, i, dir = 1, md = 0;
    int rt[4] = '{0, 0, 0, 0}, cr[4] = '{0, 0, 0, 0};
    int unit = 1, rap = 3, cut = -2;
    abc_backlash abc_backlash_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .accel_option(accel_option), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_incr(cmd_incr), .cmd_rapid(cmd_rapid),
        .accel_meas(accel_meas), .out_valid(out_valid), .out_incr(out_incr));
    abc_servo_model abc_servo_model_i (.core_clk(core_clk), .rst_n(rst_n),
        .out_valid(out_valid), .out_incr(out_incr), .position(position));
    initial forever #25 core_clk = ~core_clk;
    task check(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask
    task rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 check(reg_rdata, e);
    endtask
    // Interpolated correction over the rising prefix of rates.
    function int corr(int a);
        int n, k;
        n = rt[0] != 0;
        while (n > 0 && n < 4 && rt[n] > rt[n-1]) n++;
        il = 0;
        if (a <= rt[0]) return cr[0] * unit;
        if (a >= rt[n-1]) return cr[n-1] * unit;
        il = 49;
        k = 0;
        while (rt[k+1] <= a) k++;
        return unit * (cr[k] + (a - rt[k]) * (cr[k+1] - cr[k]) / (rt[k+1] - rt[k]));
    endfunction
    task cmd(input int inc, input logic rp, input int a, input int e, input int l);
        @(posedge core_clk);
        cmd_valid <= 1;
        cmd_incr <= 16'(inc);
        cmd_rapid <= rp;
        accel_meas <= 24'(a);
        @(posedge core_clk);
        cmd_valid <= 0;
        lat = 0;
        #1;
        while (!out_valid && lat < 60) begin
            @(posedge core_clk);
            #1 lat++;
        end
        check(32'(out_incr), 32'(e));
        check(32'(lat), 32'(l));
        pos_exp += e;
        if (lat == 60) stop_test;
        if (l) repeat (3) @(posedge core_clk);
    endtask
    task rev(input int a, input logic rp);
        int c;
        dir = -dir;
        il = 0;
        c = md ? corr(a) : (rp ? rap : cut);
        cmd(2 * dir, rp, a, 2 * dir + dir * c, il);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        for (i = 0; i < 13; i++) rd(5'(i), 0);
        rd(5'h1f, 0);
        $display("test reset done");
        wr(`ABC_REG_RAPID, rap);
        wr(`ABC_REG_CUT, cut);
        cmd(5, 0, 0, 5, 0);
        cmd(0, 0, 0, 0, 0);
        rev(0, 1);
        rev(0, 0);
        rev(0, 0);
        $display("test fixed done");
        rt = '{1000, 2000, 4000, 8000};
        cr = '{10, 30, 20, -40};
        for (i = 0; i < 4; i++) wr(5'(`ABC_REG_RATE0 + i), rt[i]);
        for (i = 0; i < 4; i++) wr(5'(`ABC_REG_CORR0 + i), cr[i]);
        rd(5'(`ABC_REG_CORR0 + 3), 32'hffffffd8);
        rd(5'(`ABC_REG_RATE0 + 1), 2000);
        wr(`ABC_REG_CTRL, 1);
        md = 1;
        rev(500, 0);
        rev(1000, 0);
        rev(3000, 1);
        rev(6000, 0);
        rev(9000, 0);
        $display("test interpolation done");
        wr(5'(`ABC_REG_RATE0 + 2), 2000);
        rt[2] = 2000;
        rev(6000, 0);
        rev(1500, 0);
        $display("test ordering done");
        wr(`ABC_REG_RATE0, 0);
        rt[0] = 0;
        md = 0;
        rev(500, 0);
        wr(`ABC_REG_RATE0, 1000);
        rt[0] = 1000;
        accel_option <= 0;
        rev(500, 1);
        accel_option <= 1;
        md = 1;
        $display("test enable done");
        wr(5'(`ABC_REG_RATE0 + 3), 0);
        rt[3] = 0;
        wr(`ABC_REG_CTRL, 3);
        unit = 10;
        rev(1000, 0);
        rev(9000, 1);
        rd(`ABC_REG_LAST, 300);
        @(posedge core_clk);
        #1 check(position, pos_exp);
        $display("test unit done");
        stop_test;
    end
endmodule
